// >>> hdl/ssp_consts.vh
// Purpose: constants for the synchronous serial port block
// Assumes: included by bare name from design files
// Notes: mode codes follow the four-bit mode field of the first control register
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// mode field codes
`define SSP_MODE_M_DIV4   4'h0
`define SSP_MODE_M_DIV16  4'h1
`define SSP_MODE_M_DIV64  4'h2
`define SSP_MODE_M_TMR    4'h3
`define SSP_MODE_S_SS     4'h4
`define SSP_MODE_S_NOSS   4'h5
`define SSP_MODE_M_RELOAD 4'hA

// divide figures for the fixed master rates
`define SSP_DIV4          16'h0004
`define SSP_DIV16         16'h0010
`define SSP_DIV64         16'h0040

// byte and counter layout
`define SSP_BITS          4'h8
`define SSP_CNT_ZERO      4'h0
`define SSP_BYTE_ZERO     8'h00
`define SSP_MSB           7

// states of the master sequencer
`define SSP_ST_IDLE       2'h0
`define SSP_ST_LEAD       2'h1
`define SSP_ST_TRAIL      2'h2

`endif

// >>> hdl/ssp_rate_gen.v
// Purpose: master bit-rate tick generator for the serial port
// Assumes: one system clock; fosc taken as the system clock rate
// Notes: emits one tick per half serial clock period
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_rate_gen #(
   parameter CW = 16
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // control
   input wire i_run,
   input wire [3:0] i_mode,
   input wire [7:0] i_reload,
   input wire i_tmr_tick,
   // tick out
   output reg o_half_tick
);

   reg [CW-1:0] cnt_ff;
   reg [CW-1:0] nxt_cnt;
   reg [CW-1:0] half_len;
   reg nxt_half_tick;

   // ******************************************************
   // half-period length per mode
   // ******************************************************
   // a full serial period of N clocks is two halves of N/2
   always @* begin
      case (i_mode)
         `SSP_MODE_M_DIV16: half_len = `SSP_DIV16 >> 1;
         `SSP_MODE_M_DIV64: half_len = `SSP_DIV64 >> 1;
         `SSP_MODE_M_RELOAD: half_len = {{(CW-10){1'b0}}, i_reload, 2'b00} + `SSP_DIV4 >> 1;
         default: half_len = `SSP_DIV4 >> 1;
      endcase
   end

   // ******************************************************
   // tick counter
   // ******************************************************
   // timer mode: every timer tick flips the serial clock phase, so the
   // serial clock runs at half the timer output rate
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_half_tick = 1'b0;
      if (!i_run) begin
         nxt_cnt = {CW{1'b0}};
      end else if (i_mode == `SSP_MODE_M_TMR) begin
         nxt_half_tick = i_tmr_tick;
      end else if (cnt_ff + {{(CW-1){1'b0}}, 1'b1} >= half_len) begin
         nxt_cnt = {CW{1'b0}};
         nxt_half_tick = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= {CW{1'b0}};
         o_half_tick <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         o_half_tick <= nxt_half_tick;
      end
   end

endmodule

// >>> hdl/ssp_port.v
// Purpose: spi master/slave logic of the synchronous serial port
// Assumes: all inputs synchronous to i_clk_sys; slave clock sampled
// Notes: slave serial clock must be slower than a quarter of i_clk_sys
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_port #(
   parameter RATE_CW = 16
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // configuration
   input wire i_port_enable_bit,
   input wire [3:0] i_mode,
   input wire i_clock_idle_level,
   input wire i_clock_edge_sel,
   input wire i_input_sample_phase,
   input wire i_buffer_overwrite_enable,
   input wire [7:0] i_rate_reload_value,
   input wire i_period_timer_output,
   input wire i_sleep,
   input wire i_int_enable,
   // software access to the transfer buffer
   input wire i_buf_wr,
   input wire [7:0] i_buf_wdata,
   input wire i_buf_rd,
   input wire i_write_collision_clr,
   input wire i_transfer_done_clr,
   // serial pins
   input wire i_sck,
   input wire i_sdi,
   input wire i_ss_b,
   input wire i_sdo_pin_en,
   // status
   output reg [7:0] o_transfer_buffer,
   output reg o_buffer_full_flag,
   output reg o_transfer_done_flag,
   output reg o_write_collision_flag,
   output reg o_wake,
   output reg o_busy,
   // serial outputs
   output reg o_sck,
   output reg o_sck_oe,
   output reg o_sdo,
   output reg o_sdo_oe
);

   // ******************************************************
   // mode decoding
   // ******************************************************
   function is_slave;
      input [3:0] mode;
      begin
         is_slave = (mode == `SSP_MODE_S_SS) || (mode == `SSP_MODE_S_NOSS);
      end
   endfunction

   wire slave = is_slave(i_mode);
   wire ss_mode = (i_mode == `SSP_MODE_S_SS);
   wire master = i_port_enable_bit && !slave;
   // module reset: port disabled, or select high in select mode
   wire mod_rst = !i_port_enable_bit || (ss_mode && i_ss_b);
   // sleep stops the master clocks, slave clock comes from the pin
   wire mclk_run = master && !i_sleep;

   reg [7:0] sr_ff;
   reg [7:0] nxt_sr;
   reg [3:0] bit_cnt_ff;
   reg [3:0] nxt_bit_cnt;
   reg [1:0] st_ff;
   reg [1:0] nxt_st;
   reg sck_ff;
   reg nxt_sck;
   reg in_ff;
   reg nxt_in;
   reg sdo_ff;
   reg nxt_sdo;
   reg [7:0] buf_ff;
   reg [7:0] nxt_buf;
   reg bf_ff;
   reg nxt_bf;
   reg done_ff;
   reg nxt_done;
   reg write_collision_flag_ff;
   reg nxt_write_collision_flag;
   reg sck_s1_ff;
   reg sck_s2_ff;
   reg sck_s3_ff;
   reg tmr_ff;
   reg byte_end;
   wire half_tick;
   wire tmr_tick;
   wire sck_edge;
   wire lead_edge;
   wire ext_active;

   // ******************************************************
   // rate generator
   // ******************************************************
   assign tmr_tick = i_period_timer_output && !tmr_ff;

   ssp_rate_gen #(
      .CW(RATE_CW)
   ) u_rate (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_run(mclk_run && st_ff != `SSP_ST_IDLE),
      .i_mode(i_mode),
      .i_reload(i_rate_reload_value),
      .i_tmr_tick(tmr_tick),
      .o_half_tick(half_tick)
   );

   // ******************************************************
   // slave clock sampling
   // ******************************************************
   // the first stage feeds only the second; edges are read on stages 2/3
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_s3_ff <= 1'b0;
         tmr_ff <= 1'b0;
      end else begin
         sck_s1_ff <= i_sck;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         tmr_ff <= i_period_timer_output;
      end
   end

   assign sck_edge = sck_s2_ff ^ sck_s3_ff;
   // leading edge leaves the idle level
   assign lead_edge = sck_edge && (sck_s3_ff == i_clock_idle_level);
   // not-selected slave ignores clock edges
   assign ext_active = i_port_enable_bit && slave && !mod_rst;

   // ******************************************************
   // shift engine
   // ******************************************************
   // edge select set: output changes on the trailing edge (into idle),
   // so bit 7 is already on the line before the first edge
   always @* begin
      nxt_sr = sr_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_st = st_ff;
      nxt_sck = sck_ff;
      nxt_in = in_ff;
      nxt_sdo = sdo_ff;
      byte_end = 1'b0;
      // slave write loads the shift register between bytes, selected or not
      if (slave && i_port_enable_bit && i_buf_wr && !write_collision_flag_ff && bit_cnt_ff == `SSP_CNT_ZERO
          && (!bf_ff || i_buffer_overwrite_enable)) begin
         nxt_sr = i_buf_wdata;
         nxt_sdo = i_buf_wdata[`SSP_MSB];
      end
      if (mod_rst) begin
         nxt_bit_cnt = `SSP_CNT_ZERO;
         nxt_st = `SSP_ST_IDLE;
         nxt_sck = i_clock_idle_level;
      end else if (master) begin
         case (st_ff)
            `SSP_ST_IDLE: begin
               nxt_sck = i_clock_idle_level;
               if (i_buf_wr && !write_collision_flag_ff) begin
                  nxt_sr = i_buf_wdata;
                  nxt_sdo = i_buf_wdata[`SSP_MSB];
                  nxt_bit_cnt = `SSP_CNT_ZERO;
                  nxt_st = `SSP_ST_LEAD;
               end
            end
            `SSP_ST_LEAD: begin
               if (half_tick && !i_sleep) begin
                  nxt_sck = !i_clock_idle_level;
                  nxt_in = i_sdi;
                  if (!i_clock_edge_sel && bit_cnt_ff != `SSP_CNT_ZERO) begin
                     nxt_sdo = sr_ff[`SSP_MSB];
                  end
                  nxt_st = `SSP_ST_TRAIL;
               end
            end
            `SSP_ST_TRAIL: begin
               if (half_tick && !i_sleep) begin
                  nxt_sck = i_clock_idle_level;
                  // late sample phase takes the bit at the trailing edge
                  nxt_sr = {sr_ff[6:0], i_input_sample_phase ? i_sdi : in_ff};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  if (i_clock_edge_sel) begin
                     nxt_sdo = sr_ff[6];
                  end
                  if (bit_cnt_ff + 4'h1 == `SSP_BITS) begin
                     byte_end = 1'b1;
                     nxt_bit_cnt = `SSP_CNT_ZERO;
                     nxt_st = `SSP_ST_IDLE;
                  end else begin
                     nxt_st = `SSP_ST_LEAD;
                  end
               end
            end
            default: nxt_st = `SSP_ST_IDLE;
         endcase
      end else if (ext_active) begin
         if (lead_edge) begin
            nxt_in = i_sdi;
            if (!i_clock_edge_sel && bit_cnt_ff != `SSP_CNT_ZERO) begin
               nxt_sdo = sr_ff[`SSP_MSB];
            end
         end else if (sck_edge) begin
            // received bits shift up and come back out unchanged
            nxt_sr = {sr_ff[6:0], in_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (i_clock_edge_sel) begin
               nxt_sdo = sr_ff[6];
            end
            if (bit_cnt_ff + 4'h1 == `SSP_BITS) begin
               byte_end = 1'b1;
               nxt_bit_cnt = `SSP_CNT_ZERO;
            end
         end
      end
   end

   // ******************************************************
   // buffer and flags
   // ******************************************************
   // set wins over clear on every flag
   always @* begin
      nxt_buf = buf_ff;
      nxt_bf = bf_ff;
      nxt_done = done_ff;
      nxt_write_collision_flag = write_collision_flag_ff;
      if (i_buf_rd) begin
         nxt_bf = 1'b0;
      end
      if (i_transfer_done_clr) begin
         nxt_done = 1'b0;
      end
      if (i_write_collision_clr) begin
         nxt_write_collision_flag = 1'b0;
      end
      if (i_buf_wr && i_port_enable_bit) begin
         if (write_collision_flag_ff || (master && st_ff != `SSP_ST_IDLE)
             || (slave && bit_cnt_ff != `SSP_CNT_ZERO)) begin
            nxt_write_collision_flag = 1'b1;
         end else if (!bf_ff || i_buffer_overwrite_enable || master) begin
            nxt_buf = i_buf_wdata;
         end
      end
      if (byte_end) begin
         nxt_buf = nxt_sr;
         nxt_bf = 1'b1;
         nxt_done = 1'b1;
      end
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sr_ff <= `SSP_BYTE_ZERO;
         bit_cnt_ff <= `SSP_CNT_ZERO;
         st_ff <= `SSP_ST_IDLE;
         sck_ff <= 1'b0;
         in_ff <= 1'b0;
         sdo_ff <= 1'b0;
         buf_ff <= `SSP_BYTE_ZERO;
         bf_ff <= 1'b0;
         done_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
      end else begin
         sr_ff <= nxt_sr;
         bit_cnt_ff <= nxt_bit_cnt;
         st_ff <= nxt_st;
         sck_ff <= nxt_sck;
         in_ff <= nxt_in;
         sdo_ff <= nxt_sdo;
         buf_ff <= nxt_buf;
         bf_ff <= nxt_bf;
         done_ff <= nxt_done;
         write_collision_flag_ff <= nxt_write_collision_flag;
      end
   end

   // ******************************************************
   // output registers
   // ******************************************************
   // select high floats the output on the same edge the counter clears
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_transfer_buffer <= `SSP_BYTE_ZERO;
         o_buffer_full_flag <= 1'b0;
         o_transfer_done_flag <= 1'b0;
         o_write_collision_flag <= 1'b0;
         o_wake <= 1'b0;
         o_busy <= 1'b0;
         o_sck <= 1'b0;
         o_sck_oe <= 1'b0;
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
      end else begin
         o_transfer_buffer <= nxt_buf;
         o_buffer_full_flag <= nxt_bf;
         o_transfer_done_flag <= nxt_done;
         o_write_collision_flag <= nxt_write_collision_flag;
         o_wake <= nxt_done && i_int_enable && slave && i_sleep;
         o_busy <= (nxt_st != `SSP_ST_IDLE) || (nxt_bit_cnt != `SSP_CNT_ZERO);
         o_sck <= nxt_sck;
         o_sck_oe <= master;
         o_sdo <= nxt_sdo;
         o_sdo_oe <= i_sdo_pin_en && i_port_enable_bit
                     && (!ss_mode || !i_ss_b);
      end
   end

endmodule

// >>> dv/ssp_port_props.sv
// Purpose: concurrent checks on the serial port top ports
// Assumes: single clock domain, reset async active low
// Notes: bound into every ssp_port instance
`timescale 1ns/1ps
`include "ssp_consts.vh"
// ****
// checker
// ****
module ssp_port_props (
   // clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // watched inputs
   input wire i_port_enable_bit,
   input wire [3:0] i_mode,
   input wire i_clock_idle_level,
   input wire i_sleep,
   input wire i_buf_wr,
   input wire i_buf_rd,
   input wire i_ss_b,
   input wire i_sdo_pin_en,
   // watched outputs
   input wire o_buffer_full_flag,
   input wire o_transfer_done_flag,
   input wire o_write_collision_flag,
   input wire o_busy,
   input wire o_sck,
   input wire o_sck_oe,
   input wire o_sdo_oe
);
   // mode decode, kept apart from the design's own
   wire mst = (i_mode < 4'h4) || (i_mode == `SSP_MODE_M_RELOAD);
   wire sel = i_port_enable_bit && (i_mode == `SSP_MODE_S_SS);
   wire wr_ok = mst && i_port_enable_bit && i_buf_wr;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // four cycles leave room for the select path latency
   sequence s_sel_held;
      (sel && !i_ss_b && i_sdo_pin_en) [*4];
   endsequence
   sequence s_idle_mst;
      (mst && i_port_enable_bit && !o_busy && !i_sleep) [*3];
   endsequence
   a_sel_drive: assert property (s_sel_held |-> o_sdo_oe)
      else $error("selected slave not driving sdo");
   a_sdo_float: assert property (sel && $rose(i_ss_b) |=> !o_sdo_oe)
      else $error("sdo still driven after deselect");
   a_busy_start: assert property (wr_ok && !o_busy && !o_write_collision_flag |=> o_busy)
      else $error("write did not start transfer");
   a_write_collision_flag_set: assert property (wr_ok && o_busy |=> o_write_collision_flag)
      else $error("collision not flagged");
   a_done_full: assert property ($rose(o_transfer_done_flag) |-> o_buffer_full_flag)
      else $error("done without buffer full");
   a_rd_clears: assert property (i_buf_rd && mst && !o_busy |=> !o_buffer_full_flag)
      else $error("read left buffer full");
   a_sleep_freeze: assert property ((mst && i_sleep && o_busy) [*3] |-> $stable(o_sck))
      else $error("master clock moved in sleep");
   a_sck_idle: assert property (s_idle_mst |-> o_sck == i_clock_idle_level)
      else $error("idle clock level wrong");
   a_port_off: assert property (!i_port_enable_bit |=> !o_busy && !o_sck_oe)
      else $error("disabled port still active");
   a_rx_only: assert property (!i_sdo_pin_en |=> !o_sdo_oe)
      else $error("sdo driven in receive only");
endmodule

bind ssp_port ssp_port_props u_props (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_port_enable_bit(i_port_enable_bit),
   .i_mode(i_mode), .i_clock_idle_level(i_clock_idle_level), .i_sleep(i_sleep),
   .i_buf_wr(i_buf_wr), .i_buf_rd(i_buf_rd), .i_ss_b(i_ss_b), .i_sdo_pin_en(i_sdo_pin_en),
   .o_buffer_full_flag(o_buffer_full_flag), .o_transfer_done_flag(o_transfer_done_flag),
   .o_write_collision_flag(o_write_collision_flag), .o_busy(o_busy), .o_sck(o_sck),
   .o_sck_oe(o_sck_oe), .o_sdo_oe(o_sdo_oe)
);

// >>> dv/ssp_spi_slave_model.sv
// Purpose: behavioural spi slave facing the port in master mode
// Assumes: clock idle level given by i_cpol, data changes on the trailing edge
// Notes: a deselected model drives the inverse of its last bit
`timescale 1ns/1ps
// ****
// partner
// ****
module ssp_spi_slave_model (
   // serial side
   input wire i_sck,
   input wire i_cpol,
   input wire i_mosi,
   input wire i_en,
   // byte side
   input wire [7:0] i_tx,
   output reg [7:0] o_rx,
   output wire o_miso
);
   reg [7:0] sh_ff;
   // load at frame start so bit 7 is out before the first edge
   always @(posedge i_en) begin
      sh_ff = i_tx;
   end
   // leading edge leaves idle and samples, new bit at the bottom;
   // trailing edge shifts out, top bit first
   always @(i_sck) begin
      if (i_en && (i_sck !== i_cpol)) o_rx = {o_rx[6:0], i_mosi};
      else if (i_en) sh_ff = {sh_ff[6:0], 1'b0};
   end
   // a released line never shows a stale level
   assign o_miso = i_en ? sh_ff[7] : ~sh_ff[7];
endmodule

// >>> dv/test_ssp_port.sv
// Purpose: self-checking bench for the serial port
// Assumes: 40 MHz clock, data out on trailing edge, idle level varied in master runs
// Notes: bench plays the master itself in slave mode
`timescale 1ns/1ps
`include "ssp_consts.vh"
// ****
// bench
// ****
module test_ssp_port;
   reg clk = 1'b0, rst_b = 1'b0, en = 1'b0, slp = 1'b0, ie = 1'b0, buffer_overwrite_enable = 1'b0;
   reg wr = 1'b0, rd = 1'b0, wclr = 1'b0, dclr = 1'b0, sck = 1'b0, sdi_s = 1'b0;
   reg ss_b = 1'b1, pe = 1'b1, mst = 1'b1, p_en = 1'b0, clock_idle_level = 1'b0, input_sample_phase = 1'b0;
   reg [1:0] tc = 2'h0;
   reg [3:0] mode = 4'h0;
   reg [7:0] rv = 8'h00, wd = 8'h00, p_tx = 8'h00, cap = 8'h00;
   wire [7:0] bq, p_rx;
   wire full, done, write_collision_flag, wake, busy, msck, msck_oe, sdo, sdo_oe, miso;
   integer err_total = 0, samples_checked = 0, n;
   always #12.5 clk = ~clk;
   // timer output rises every four clocks
   always @(posedge clk) tc <= tc + 2'h1;
   ssp_port uut (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_port_enable_bit(en), .i_mode(mode),
      .i_clock_idle_level(clock_idle_level), .i_clock_edge_sel(1'b1),
      .i_input_sample_phase(input_sample_phase),
      .i_buffer_overwrite_enable(buffer_overwrite_enable), .i_rate_reload_value(rv),
      .i_period_timer_output(tc[1]), .i_sleep(slp), .i_int_enable(ie), .i_buf_wr(wr),
      .i_buf_wdata(wd), .i_buf_rd(rd), .i_write_collision_clr(wclr),
      .i_transfer_done_clr(dclr), .i_sck(sck), .i_sdi(mst ? miso : sdi_s), .i_ss_b(ss_b),
      .i_sdo_pin_en(pe), .o_transfer_buffer(bq), .o_buffer_full_flag(full),
      .o_transfer_done_flag(done), .o_write_collision_flag(write_collision_flag), .o_wake(wake),
      .o_busy(busy), .o_sck(msck), .o_sck_oe(msck_oe), .o_sdo(sdo), .o_sdo_oe(sdo_oe));
   ssp_spi_slave_model u_partner (.i_sck(msck), .i_cpol(clock_idle_level), .i_mosi(sdo_oe ? sdo : ~sdo),
      .i_en(p_en), .i_tx(p_tx), .o_rx(p_rx), .o_miso(miso));
   task tick; begin @(posedge clk); #1; end endtask
   task chk(input [7:0] got, input [7:0] exp); begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   end endtask
   task give_verdict; begin
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   end endtask
   task pulse_wr(input [7:0] d); begin wd = d; wr = 1'b1; tick; wr = 1'b0; end endtask
   task clr; begin rd = 1'b1; dclr = 1'b1; wclr = 1'b1; tick; rd = 1'b0; dclr = 1'b0; wclr = 1'b0; end
   endtask
   // bounded waits, the count is left in n
   task wlev(input v); begin n = 0; while (msck !== v && n < 3000) begin tick; n = n + 1; end
   end endtask
   task wait_done; begin
      n = 0;
      while (done !== 1'b1 && n < 3000) begin tick; n = n + 1; end
      if (n >= 3000) chk(8'h00, 8'h01);
   end endtask
   // one master byte: rate, collision, optional sleep, result
   task mx(input [3:0] m, input [7:0] r, input [7:0] tx, input [7:0] ptx, input [7:0] h,
           input sl); begin
      en = 1'b0;
      tick;
      mode = m;
      rv = r;
      mst = 1'b1;
      p_tx = ptx;
      en = 1'b1;
      p_en = 1'b1;
      repeat (2) tick;
      pulse_wr(tx);
      wlev(~clock_idle_level);
      wlev(clock_idle_level);
      chk(n[7:0], h);
      pulse_wr(8'h5A);
      chk({7'h0, write_collision_flag}, 8'h01);
      chk({7'h0, busy}, 8'h01);
      if (!pe) chk({7'h0, sdo_oe}, 8'h00);
      if (sl) begin
         slp = 1'b1;
         repeat (3) tick;
         cap = {7'h0, msck};
         repeat (30) tick;
         chk({7'h0, msck}, cap);
         slp = 1'b0;
      end
      wait_done;
      chk(bq, ptx);
      if (pe) chk(p_rx, tx);
      chk({7'h0, full}, 8'h01);
      p_en = 1'b0;
      clr;
      chk({6'h0, full, write_collision_flag}, 8'h00);
   end endtask
   // bench acts as master: nb bits, sdo sampled before each leading edge
   task sx(input [7:0] mo, input integer nb);
      integer i;
      begin
         ss_b = 1'b0;
         repeat (4) tick;
         chk({7'h0, sdo_oe}, 8'h01);
         for (i = 7; i > 7 - nb; i = i - 1) begin
            sdi_s = mo[i];
            repeat (6) tick;
            cap[i] = sdo;
            sck = 1'b1;
            repeat (6) tick;
            sck = 1'b0;
         end
         repeat (6) tick;
         ss_b = 1'b1;
         repeat (2) tick;
         chk({7'h0, sdo_oe}, 8'h00);
      end
   endtask
   // stalled runs end here too
   initial begin
      #500000;
      err_total = err_total + 1;
      give_verdict;
   end
   // main sequence
   initial begin
      repeat (5) tick;
      rst_b = 1'b1;
      repeat (2) tick;
      mx(`SSP_MODE_M_DIV4, 8'h00, 8'hA5, 8'h3C, 8'h02, 1'b0);
      mx(`SSP_MODE_M_DIV16, 8'h00, 8'h81, 8'h7E, 8'h08, 1'b0);
      mx(`SSP_MODE_M_DIV64, 8'h00, 8'h01, 8'hFE, 8'h20, 1'b0);
      mx(`SSP_MODE_M_TMR, 8'h00, 8'hC6, 8'h39, 8'h04, 1'b0);
      mx(`SSP_MODE_M_RELOAD, 8'h02, 8'h5A, 8'hA5, 8'h06, 1'b0);
      // idle-high clock with late input sampling, changed only while disabled
      en = 1'b0;
      clock_idle_level = 1'b1;
      input_sample_phase = 1'b1;
      tick;
      mx(`SSP_MODE_M_DIV4, 8'h00, 8'h3C, 8'hC3, 8'h02, 1'b0);
      en = 1'b0;
      clock_idle_level = 1'b0;
      input_sample_phase = 1'b0;
      tick;
      pe = 1'b0;
      mx(`SSP_MODE_M_DIV16, 8'h00, 8'hF0, 8'h0F, 8'h08, 1'b1);
      pe = 1'b1;
      en = 1'b0;
      tick;
      sck = 1'b0;
      mode = `SSP_MODE_S_SS;
      mst = 1'b0;
      en = 1'b1;
      repeat (2) tick;
      pulse_wr(8'h96);
      sx(8'h5B, 8);
      chk(cap, 8'h96);
      chk(bq, 8'h5B);
      chk({7'h0, done}, 8'h01);
      chk({7'h0, msck_oe}, 8'h00);
      sx(8'hE1, 8);
      chk(cap, 8'h5B);
      // unread byte and no overwrite: the write must not land
      pulse_wr(8'h77);
      chk(bq, 8'hE1);
      tick;
      buffer_overwrite_enable = 1'b1;
      pulse_wr(8'hC3);
      chk({7'h0, write_collision_flag}, 8'h00);
      sx(8'h00, 8);
      chk(cap, 8'hC3);
      clr;
      sx(8'hFF, 3);
      // clock edges while deselected must be ignored
      repeat (3) begin
         sck = 1'b1;
         repeat (6) tick;
         sck = 1'b0;
         repeat (6) tick;
      end
      sx(8'h69, 8);
      chk(bq, 8'h69);
      clr;
      slp = 1'b1;
      ie = 1'b1;
      sx(8'h2D, 8);
      chk(bq, 8'h2D);
      chk({7'h0, wake}, 8'h01);
      slp = 1'b0;
      give_verdict;
   end
endmodule
